// >>> logic/bridge_pkg.sv
// package: register map, field layout, timing constants and carriers
package bridge_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] off_baud = 12'h000;   // requested baud rate
    localparam logic [11:0] off_line = 12'h004;   // parity, stop bits, mode
    localparam logic [11:0] off_ctrl = 12'h008;   // session and led modes
    localparam logic [11:0] off_stat = 12'h00c;   // status
    localparam logic [11:0] off_txd = 12'h010;    // host byte to send
    localparam logic [11:0] off_rxd = 12'h014;    // captured byte
    localparam logic [11:0] off_div = 12'h018;    // effective divider

    // ------------------------------------------------------------
    // line control fields
    // ------------------------------------------------------------
    localparam int line_par_lo = 0;      // parity select, two bits
    localparam int line_stop2 = 2;       // two stop bits
    localparam int line_newfw = 3;       // tristate tx after close
    localparam logic [1:0] par_none = 2'h0;
    localparam logic [1:0] par_odd = 2'h1;
    localparam logic [1:0] par_even = 2'h2;

    // control fields
    localparam int ctrl_dtr = 0;         // session open flag
    localparam int ctrl_boot = 1;        // boot loader mode
    localparam int ctrl_prog = 2;        // programming in progress
    localparam int ctrl_fault = 3;       // power fault
    localparam int ctrl_sleep = 4;       // controller asleep
    localparam int ctrl_dnd_ok = 5;      // write 1: success report
    localparam int ctrl_dnd_fail = 6;    // write 1: failure report

    // status fields
    localparam int stat_tx_busy = 0;
    localparam int stat_tx_full = 1;
    localparam int stat_rx_valid = 2;
    localparam int stat_tx_drive = 3;
    localparam int stat_par_err = 4;
    localparam int stat_frm_err = 5;

    // ------------------------------------------------------------
    // baud span and timing
    // ------------------------------------------------------------
    localparam int clk_hz = 250000000;
    localparam logic [31:0] baud_min = 32'h0000_04b0;   // 1200 bps
    localparam logic [31:0] baud_max = 32'h0007_a120;   // 500000 bps
    localparam logic [31:0] baud_reset = 32'h0000_2580; // 9600 bps
    localparam int slow_hz = 1;
    localparam int fast_hz = 5;
    localparam int report_s = 2;
    // half periods of the led toggles and the report time, in cycles
    localparam int slow_half = clk_hz / (2 * slow_hz);
    localparam int fast_half = clk_hz / (2 * fast_hz);
    localparam int report_cyc = clk_hz * report_s;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] parity;   // none, odd or even
        logic stop2;          // two stop bits
    } frame_cfg_t;

    typedef struct packed {
        logic boot;
        logic prog;
        logic fault;
        logic sleep;
        logic dnd_ok;         // pulse: report success
        logic dnd_fail;       // pulse: report failure
    } led_req_t;

endpackage : bridge_pkg

// >>> logic/status_led.sv
// status led pattern generator
`timescale 1ns/1ps
module status_led #(
    parameter int slow_half = bridge_pkg::slow_half,
    parameter int fast_half = bridge_pkg::fast_half,
    parameter int report_cyc = bridge_pkg::report_cyc
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire bridge_pkg::led_req_t req,
    output logic power_status_led
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {show_on, show_slow, show_fast, show_off} show_t;
    typedef struct packed {
        logic [31:0] phase;    // blink phase counter
        logic [31:0] report;   // remaining report time
        logic rep_fail;        // report is a failure
        logic blink;           // current blink level
        logic led;
    } led_state_t;

    led_state_t cur, nxt;
    show_t show;

    // pattern priority: off, fault, report, boot/prog, steady on
    always_comb
    begin
        if (req.sleep)
            show = show_off;
        else if (req.fault)
            show = show_fast;
        else if (cur.report != 32'h0)
            show = cur.rep_fail ? show_fast : show_slow;
        else if (req.boot || req.prog)
            show = show_slow;
        else
            show = show_on;
    end

    // next state
    always_comb
    begin
        nxt = cur;
        if (req.dnd_ok || req.dnd_fail)
        begin
            nxt.report = 32'(report_cyc);
            nxt.rep_fail = req.dnd_fail;
        end
        else if (cur.report != 32'h0)
            nxt.report = cur.report - 32'h1;
        // toggle at the selected rate
        if ((show == show_slow && cur.phase >= 32'(slow_half - 1)) ||
            (show == show_fast && cur.phase >= 32'(fast_half - 1)))
        begin
            nxt.phase = 32'h0;
            nxt.blink = ~cur.blink;
        end
        else
            nxt.phase = cur.phase + 32'h1;
        case (show)
            show_on: nxt.led = 1'b1;
            show_slow: nxt.led = cur.blink;
            show_fast: nxt.led = cur.blink;
            show_off: nxt.led = 1'b0;
            default: nxt.led = 1'b0;
        endcase
    end

    // register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur <= '0;
        else
            cur <= nxt;
    end

    assign power_status_led = cur.led;

    a_led_dark_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        req.sleep |=> !power_status_led)
        else $error("led lit while asleep");
endmodule : status_led

// >>> logic/uart_bridge.sv
// usb serial uart bridge: apb registers, uart tx/rx, session gating
`timescale 1ns/1ps
module uart_bridge #(
    parameter int slow_half = bridge_pkg::slow_half,
    parameter int fast_half = bridge_pkg::fast_half,
    parameter int report_cyc = bridge_pkg::report_cyc
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bridge_receive_pin,
    output logic bridge_transmit_pin,
    output logic bridge_transmit_oe_n,
    output logic power_status_led
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {tx_idle, tx_start, tx_data, tx_par, tx_stop}
        tx_phase_t;
    typedef enum logic [2:0] {rx_idle, rx_start, rx_data, rx_par, rx_stop}
        rx_phase_t;

    typedef struct packed {
        logic [31:0] baud;          // clamped baud rate
        logic [31:0] divider;       // cycles per bit
        bridge_pkg::frame_cfg_t cfg;
        logic newfw;                // tristate after close
        logic [6:0] ctrl;           // session and led mode bits
        logic enabled;              // session was ever opened
        logic drive;                // level shifter enabled
        logic [7:0] hold;           // one byte queue
        logic hold_full;
        tx_phase_t tph;
        logic [31:0] tcnt;
        logic [2:0] tbit;
        logic [7:0] tsh;
        logic tpar;
        logic tstop;                // second stop bit pending
        logic txo;
        logic [1:0] rsync;          // pin synchroniser
        rx_phase_t rph;
        logic [31:0] rcnt;
        logic [2:0] rbit;
        logic [7:0] rsh;
        logic rpar;
        logic rstop;
        logic [7:0] rdata;
        logic rvalid;
        logic perr;
        logic ferr;
    } br_state_t;

    br_state_t cur, nxt;
    bridge_pkg::led_req_t led_req;
    logic wr, rd, rx_in;
    logic [31:0] req_baud;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign rx_in = cur.rsync[1];
    assign req_baud = pwdata;

    // clamped value written to the baud register
    function automatic logic [31:0] clamp(input logic [31:0] b);
        if (b < bridge_pkg::baud_min)
            clamp = bridge_pkg::baud_min;
        else if (b > bridge_pkg::baud_max)
            clamp = bridge_pkg::baud_max;
        else
            clamp = b;
    endfunction : clamp

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt = cur;
        nxt.ctrl[bridge_pkg::ctrl_dnd_ok] = 1'b0;
        nxt.ctrl[bridge_pkg::ctrl_dnd_fail] = 1'b0;
        nxt.rsync = {cur.rsync[0], bridge_receive_pin};

        // register writes; line settings always usable
        if (wr)
        begin
            case (paddr)
                bridge_pkg::off_baud:
                begin
                    nxt.baud = clamp(req_baud);
                    nxt.divider = 32'(bridge_pkg::clk_hz) / clamp(req_baud);
                end
                bridge_pkg::off_line:
                begin
                    nxt.cfg.parity = pwdata[bridge_pkg::line_par_lo +: 2];
                    nxt.cfg.stop2 = pwdata[bridge_pkg::line_stop2];
                    nxt.newfw = pwdata[bridge_pkg::line_newfw];
                end
                bridge_pkg::off_ctrl: nxt.ctrl = pwdata[6:0];
                default: ;
            endcase
        end

        // session open: shifters on
        if (cur.ctrl[bridge_pkg::ctrl_dtr])
        begin
            nxt.enabled = 1'b1;
            nxt.drive = 1'b1;
        end
        else if (cur.newfw && cur.tph == tx_idle && !cur.hold_full)
            nxt.drive = 1'b0;
        else if (!cur.newfw && cur.enabled)
            nxt.drive = 1'b1;

        // host byte accepted only in session, into a free slot
        if (wr && paddr == bridge_pkg::off_txd &&
            cur.ctrl[bridge_pkg::ctrl_dtr] && !cur.hold_full)
        begin
            nxt.hold = pwdata[7:0];
            nxt.hold_full = 1'b1;
        end

        // transmitter: drains queue even after close
        case (cur.tph)
            tx_idle:
            begin
                nxt.txo = 1'b1;
                if (cur.hold_full)
                begin
                    nxt.tsh = cur.hold;
                    nxt.hold_full = 1'b0;
                    nxt.tpar = ^cur.hold ^ (cur.cfg.parity == bridge_pkg::par_odd);
                    nxt.tph = tx_start;
                    nxt.tcnt = '0;
                    nxt.txo = 1'b0;
                end
            end
            default:
            begin
                nxt.tcnt = cur.tcnt + 32'h1;
                if (cur.tcnt >= cur.divider - 32'h1)
                begin
                    nxt.tcnt = '0;
                    case (cur.tph)
                        tx_start:
                        begin
                            nxt.tph = tx_data;
                            nxt.tbit = '0;
                            nxt.txo = cur.tsh[0];
                        end
                        tx_data:
                        begin
                            if (cur.tbit == 3'h7)
                            begin
                                if (cur.cfg.parity != bridge_pkg::par_none)
                                begin
                                    nxt.tph = tx_par;
                                    nxt.txo = cur.tpar;
                                end
                                else
                                begin
                                    nxt.tph = tx_stop;
                                    nxt.tstop = cur.cfg.stop2;
                                    nxt.txo = 1'b1;
                                end
                            end
                            else
                            begin
                                nxt.tbit = cur.tbit + 3'h1;
                                nxt.txo = cur.tsh[3'(cur.tbit + 3'h1)];
                            end
                        end
                        tx_par:
                        begin
                            nxt.tph = tx_stop;
                            nxt.tstop = cur.cfg.stop2;
                            nxt.txo = 1'b1;
                        end
                        tx_stop:
                        begin
                            if (cur.tstop)
                                nxt.tstop = 1'b0;
                            else
                                nxt.tph = tx_idle;
                        end
                        default: nxt.tph = tx_idle;
                    endcase
                end
            end
        endcase

        // reads clear flags first, so a same-cycle set below wins
        if (rd && paddr == bridge_pkg::off_rxd)
            nxt.rvalid = 1'b0;
        if (rd && paddr == bridge_pkg::off_stat)
        begin
            nxt.perr = 1'b0;
            nxt.ferr = 1'b0;
        end

        // receiver: only while session active
        if (!cur.ctrl[bridge_pkg::ctrl_dtr])
            nxt.rph = rx_idle;
        else
        begin
            case (cur.rph)
                rx_idle:
                    if (!rx_in)
                    begin
                        nxt.rph = rx_start;
                        nxt.rcnt = '0;
                    end
                default:
                begin
                    nxt.rcnt = cur.rcnt + 32'h1;
                    // start bit checked mid bit, others one bit later
                    if ((cur.rph == rx_start &&
                         cur.rcnt >= (cur.divider >> 1)) ||
                        (cur.rph != rx_start &&
                         cur.rcnt >= cur.divider - 32'h1))
                    begin
                        nxt.rcnt = '0;
                        case (cur.rph)
                            rx_start:
                            begin
                                nxt.rph = rx_in ? rx_idle : rx_data;
                                nxt.rbit = '0;
                                // no stale parity error from an old frame
                                nxt.rpar = 1'b0;
                            end
                            rx_data:
                            begin
                                nxt.rsh = {rx_in, cur.rsh[7:1]};
                                nxt.rbit = cur.rbit + 3'h1;
                                if (cur.rbit == 3'h7)
                                begin
                                    nxt.rstop = cur.cfg.stop2;
                                    nxt.rph = (cur.cfg.parity !=
                                        bridge_pkg::par_none) ? rx_par : rx_stop;
                                end
                            end
                            rx_par:
                            begin
                                nxt.rpar = rx_in ^ ^cur.rsh ^
                                    (cur.cfg.parity == bridge_pkg::par_odd);
                                nxt.rph = rx_stop;
                            end
                            rx_stop:
                            begin
                                if (!rx_in)
                                begin
                                    nxt.ferr = 1'b1;
                                    nxt.rph = rx_idle;
                                end
                                else if (cur.rstop)
                                    nxt.rstop = 1'b0;
                                else
                                begin
                                    nxt.rdata = cur.rsh;
                                    nxt.rvalid = 1'b1;
                                    nxt.perr = nxt.perr | cur.rpar;
                                    nxt.rph = rx_idle;
                                end
                            end
                            default: nxt.rph = rx_idle;
                        endcase
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur <= '0;
            cur.baud <= bridge_pkg::baud_reset;
            cur.divider <= 32'(bridge_pkg::clk_hz) / bridge_pkg::baud_reset;
            cur.newfw <= 1'b1;
            cur.txo <= 1'b1;
            cur.rsync <= 2'h3;
        end
        else
            cur <= nxt;
    end

    // ------------------------------------------------------------
    // apb read, pins, led
    // ------------------------------------------------------------
    always_comb
    begin
        case (paddr)
            bridge_pkg::off_baud: prdata = cur.baud;
            bridge_pkg::off_line: prdata = {28'h0, cur.newfw, cur.cfg};
            bridge_pkg::off_ctrl: prdata = {25'h0, cur.ctrl};
            bridge_pkg::off_stat: prdata = {26'h0, cur.ferr, cur.perr,
                cur.drive, cur.rvalid, cur.hold_full, cur.tph != tx_idle};
            bridge_pkg::off_rxd: prdata = {24'h0, cur.rdata};
            bridge_pkg::off_div: prdata = cur.divider;
            default: prdata = 32'h0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == bridge_pkg::off_baud ||
        paddr == bridge_pkg::off_line || paddr == bridge_pkg::off_ctrl ||
        paddr == bridge_pkg::off_stat || paddr == bridge_pkg::off_txd ||
        paddr == bridge_pkg::off_rxd || paddr == bridge_pkg::off_div);
    // no rts/cts pins exist; only tx and rx lines
    assign bridge_transmit_pin = cur.txo;
    assign bridge_transmit_oe_n = !cur.drive;

    assign led_req.boot = cur.ctrl[bridge_pkg::ctrl_boot];
    assign led_req.prog = cur.ctrl[bridge_pkg::ctrl_prog];
    assign led_req.fault = cur.ctrl[bridge_pkg::ctrl_fault];
    assign led_req.sleep = cur.ctrl[bridge_pkg::ctrl_sleep];
    assign led_req.dnd_ok = cur.ctrl[bridge_pkg::ctrl_dnd_ok];
    assign led_req.dnd_fail = cur.ctrl[bridge_pkg::ctrl_dnd_fail];

    status_led #(
        .slow_half(slow_half),
        .fast_half(fast_half),
        .report_cyc(report_cyc)
    ) u_led (
        .pclk(pclk),
        .presetn(presetn),
        .req(led_req),
        .power_status_led(power_status_led)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_baud_in_span: assert property (@(posedge pclk) disable iff (!presetn)
        cur.baud >= bridge_pkg::baud_min && cur.baud <= bridge_pkg::baud_max)
        else $error("baud outside span");
    a_baud_clamp_low: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == bridge_pkg::off_baud && pwdata < bridge_pkg::baud_min
        |=> cur.baud == bridge_pkg::baud_min)
        else $error("low baud not clamped");
    a_baud_onfly: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == bridge_pkg::off_baud |=> cur.baud == clamp($past(pwdata)))
        else $error("baud write lost");
    a_refuse_closed: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == bridge_pkg::off_txd && !cur.ctrl[bridge_pkg::ctrl_dtr]
        && !cur.hold_full |=> !cur.hold_full)
        else $error("byte taken without session");
    a_rx_off_closed: assert property (@(posedge pclk) disable iff (!presetn)
        !cur.ctrl[bridge_pkg::ctrl_dtr] |=> cur.rph == rx_idle)
        else $error("receiver active without session");
    a_tx_undriven: assert property (@(posedge pclk) disable iff (!presetn)
        !cur.enabled |-> bridge_transmit_oe_n)
        else $error("tx driven before enable");
    a_idle_high: assert property (@(posedge pclk) disable iff (!presetn)
        cur.tph == tx_idle && !$past(cur.hold_full) |-> bridge_transmit_pin)
        else $error("line not idle high");
    a_old_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        !cur.newfw && cur.enabled ##1 !cur.newfw |-> cur.drive)
        else $error("old mode released line");
endmodule : uart_bridge

// >>> tb/target_uart.sv
// target side uart model: decodes tx frames and sends rx frames
`timescale 1ns/1ps
module target_uart #(
    parameter int div = 500
) (
    input wire logic pclk,
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got = 8'h00; // last byte decoded
    logic got_par = 1'b0; // its parity bit
    int frames = 0; // frames decoded so far
    initial line_out = 1'b1; // idle high
    // decode: start, eight data lsb first, parity, stop
    always
    begin
        @(negedge line_in);
        repeat (div / 2) @(posedge pclk);
        for (int i = 0; i < 9; i++)
        begin
            repeat (div) @(posedge pclk);
            if (i < 8)
                got[i] = line_in;
            else
                got_par = line_in;
        end
        repeat (div) @(posedge pclk);
        frames++;
    end
    // send one frame with even parity and one stop bit
    task automatic send(input logic [7:0] b);
        logic [10:0] f;
        f = {1'b1, ^b, b, 1'b0};
        for (int i = 0; i < 11; i++)
        begin
            line_out <= f[i];
            repeat (div) @(posedge pclk);
        end
    endtask : send
endmodule : target_uart

// >>> tb/uart_bridge_tb_top.sv
// testbench top: apb tasks and serial scenarios for the bridge
`timescale 1ns/1ps
module uart_bridge_tb_top;
    logic pclk = 1'b0, presetn, psel, penable;
    logic pwrite, pready, pslverr, rx, tx, oe_n, led, rd_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_val;
    int errors = 0, checks = 0, t;
    wire logic tx_line = oe_n ? 1'b1 : tx; // target pull-up
    initial forever #2 pclk = ~pclk;
    uart_bridge #(.slow_half(20), .fast_half(4), .report_cyc(200)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bridge_receive_pin(rx),
        .bridge_transmit_pin(tx), .bridge_transmit_oe_n(oe_n),
        .power_status_led(led));
    target_uart #(.div(500)) u (.pclk(pclk), .line_in(tx_line),
        .line_out(rx));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : xfer
    task automatic waitf(input int n);
        for (int i = 0; i < 20000 && u.frames < n; i++) @(posedge pclk);
    endtask : waitf
    task automatic print_verdict;
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #(4 * 80000); // tests need well under 60000 cycles
        errors++;
        print_verdict();
    end
    initial
    begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 12'h000;
        pwdata <= 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        chk(oe_n, 1);
        xfer(0, 12'h000, 0); chk(rd_val, 32'h2580);
        xfer(1, 12'h000, 32'h000f_4240); xfer(0, 12'h000, 0);
        chk(rd_val, 32'h0007_a120);
        xfer(0, 12'h018, 0); chk(rd_val, 32'd500);
        xfer(1, 12'h000, 32'h10); xfer(0, 12'h000, 0);
        chk(rd_val, 32'h4b0);
        xfer(1, 12'h000, 32'h0007_a120);
        xfer(0, 12'h01c, 0); chk(rd_val, 0);
        chk(rd_err, 1);
        xfer(1, 12'h004, 32'ha); // even parity, new close mode
        xfer(1, 12'h010, 32'h55); xfer(0, 12'h00c, 0);
        chk(rd_val[0], 0);
        xfer(1, 12'h008, 1); repeat (2) @(posedge pclk);
        chk(oe_n, 0);
        xfer(1, 12'h010, 32'ha7); waitf(1);
        chk({u.got_par, u.got}, 9'h1a7);
        u.send(8'h3c); xfer(0, 12'h014, 0);
        chk(rd_val[7:0], 8'h3c);
        xfer(1, 12'h010, 32'h81); xfer(1, 12'h008, 0);
        xfer(1, 12'h010, 32'h22); waitf(2);
        chk(u.got, 8'h81);
        repeat (1000) @(posedge pclk);
        chk(oe_n, 1);
        waitf(3); chk(u.frames, 2);
        u.send(8'h44); xfer(0, 12'h00c, 0);
        chk(rd_val[2], 0);
        xfer(1, 12'h008, 32'h10); repeat (2) @(posedge pclk);
        chk(led, 0);
        xfer(1, 12'h008, 32'h8); t = 0;
        for (int i = 0; i < 40; i++) @(posedge pclk) t += (led !== 1'b0);
        chk(t, 20);
        print_verdict();
    end
endmodule : uart_bridge_tb_top
